// ===== brk_pkg.sv
// package for the break control register block: offsets, fields, carriers
package brk_pkg;
    // register byte offsets
    localparam logic [7:0] BRK_OFS_CTRL = 8'h00;
    localparam logic [7:0] BRK_OFS_STAT = 8'h04;
    localparam logic [7:0] BRK_OFS_MASK = 8'h08;
    localparam logic [7:0] BRK_OFS_ASIDA = 8'h0c;
    localparam logic [7:0] BRK_OFS_ASIDB = 8'h10;
    // break_control field positions
    localparam int BRK_B_ASID_MASK_A = 21;
    localparam int BRK_B_ASID_MASK_B = 20;
    localparam int BRK_B_FLAG_LO = 12;
    localparam int BRK_B_PC_TRACE = 11;
    localparam int BRK_B_AFTER_A = 10;
    localparam int BRK_B_SEQ = 3;
    // bits of break_control that hold state; all others read zero
    localparam logic [31:0] BRK_CTRL_RW_MASK = 32'h0030_fc08;
    // reset values
    localparam logic [31:0] BRK_CTRL_RST = 32'h0000_0000;
    localparam logic [3:0] BRK_FLAG_RST = 4'h0;
    localparam logic [7:0] BRK_ASID_RST = 8'h00;
    localparam logic [31:0] BRK_RDATA_RST = 32'h0000_0000;
    // flag / status index: 3 L bus A, 2 L bus B, 1 I bus A, 0 I bus B
    localparam int BRK_NFLAG = 4;

    // one cycle of a monitored bus (L bus or I bus)
    typedef struct packed {
        logic valid;
        logic fetch;
        logic [7:0] asid;
        logic cond_a;
        logic cond_b;
    } brk_bus_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } brk_apb_req_t;
endpackage : brk_pkg

// ===== brk_ctrl.sv
// break control register with match flags, asid check, timing select and apb slave
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module brk_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // apb slave
    input wire brk_pkg::brk_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // monitored buses
    input wire brk_pkg::brk_bus_t lbus,
    input wire brk_pkg::brk_bus_t ibus,
    input wire logic insn_exec_done,
    // break and trace outputs
    output logic brk_before,
    output logic brk_after,
    output logic pc_trace_en,
    output logic irq
);
    logic [31:0] ctrl_r;
    logic [3:0] flag_r;
    logic [3:0] stat_r;
    logic [3:0] mask_r;
    logic [7:0] asid_a_r;
    logic [7:0] asid_b_r;
    logic seq_armed_r;
    logic after_pend_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic brk_before_r;
    logic brk_after_r;
    logic irq_r;
    logic [3:0] hit;
    logic [3:0] a_hit_raw;
    logic b_ok;
    logic wr_en;
    logic ctrl_wr;
    logic stat_wr;
    logic a_fetch_hit;

    // a channel meets its condition when the bus runs, the outer compare hits,
    // and the asid agrees or is masked out
    function automatic logic chan_hit(input logic valid, input logic cond,
                                      input logic [7:0] asid, input logic [7:0] want,
                                      input logic skip);
        chan_hit = valid & cond & (skip | (asid == want));
    endfunction : chan_hit

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == brk_pkg::BRK_OFS_CTRL) || (a == brk_pkg::BRK_OFS_STAT) ||
                     (a == brk_pkg::BRK_OFS_MASK) || (a == brk_pkg::BRK_OFS_ASIDA) ||
                     (a == brk_pkg::BRK_OFS_ASIDB);
    endfunction : addr_known

    // apb: one wait state, write lands at the edge where pready is seen high
    assign wr_en = apb_req.psel & apb_req.penable & pready_r & apb_req.pwrite;
    assign ctrl_wr = wr_en & (apb_req.paddr == brk_pkg::BRK_OFS_CTRL);
    assign stat_wr = wr_en & (apb_req.paddr == brk_pkg::BRK_OFS_STAT);

    // channel B is held off in sequential mode until channel A has matched
    assign b_ok = ~ctrl_r[brk_pkg::BRK_B_SEQ] | seq_armed_r;

    assign a_hit_raw[3] = chan_hit(lbus.valid, lbus.cond_a, lbus.asid, asid_a_r,
                                   ctrl_r[brk_pkg::BRK_B_ASID_MASK_A]);
    assign a_hit_raw[1] = chan_hit(ibus.valid, ibus.cond_a, ibus.asid, asid_a_r,
                                   ctrl_r[brk_pkg::BRK_B_ASID_MASK_A]);
    assign a_hit_raw[2] = chan_hit(lbus.valid, lbus.cond_b, lbus.asid, asid_b_r,
                                   ctrl_r[brk_pkg::BRK_B_ASID_MASK_B]);
    assign a_hit_raw[0] = chan_hit(ibus.valid, ibus.cond_b, ibus.asid, asid_b_r,
                                   ctrl_r[brk_pkg::BRK_B_ASID_MASK_B]);
    assign hit = {a_hit_raw[3], a_hit_raw[2] & b_ok, a_hit_raw[1], a_hit_raw[0] & b_ok};
    assign a_fetch_hit = (a_hit_raw[3] & lbus.fetch) | (a_hit_raw[1] & ibus.fetch);

    // setting bits of break_control
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= brk_pkg::BRK_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_r <= apb_req.pwdata & brk_pkg::BRK_CTRL_RW_MASK;
        end
    end

    // match flags: cleared only by a written zero; status bits: cleared only by a written one to the status register; a new match wins
    generate
        for (genvar i = 0; i < brk_pkg::BRK_NFLAG; i++) begin : g_flag
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    flag_r[i] <= 1'b0;
                end else if (hit[i]) begin
                    flag_r[i] <= 1'b1;
                end else if (ctrl_wr && !apb_req.pwdata[brk_pkg::BRK_B_FLAG_LO + i]) begin
                    flag_r[i] <= 1'b0;
                end
            end
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    stat_r[i] <= 1'b0;
                end else if (hit[i]) begin
                    stat_r[i] <= 1'b1;
                end else if (stat_wr && apb_req.pwdata[i]) begin
                    stat_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // interrupt mask and asid compare values
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_r <= brk_pkg::BRK_FLAG_RST;
            asid_a_r <= brk_pkg::BRK_ASID_RST;
            asid_b_r <= brk_pkg::BRK_ASID_RST;
        end else if (wr_en) begin
            if (apb_req.paddr == brk_pkg::BRK_OFS_MASK) begin
                mask_r <= apb_req.pwdata[3:0];
            end
            if (apb_req.paddr == brk_pkg::BRK_OFS_ASIDA) begin
                asid_a_r <= apb_req.pwdata[7:0];
            end
            if (apb_req.paddr == brk_pkg::BRK_OFS_ASIDB) begin
                asid_b_r <= apb_req.pwdata[7:0];
            end
        end
    end

    // sequence arm: a counted channel B match consumes it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_armed_r <= 1'b0;
        end else if (!ctrl_r[brk_pkg::BRK_B_SEQ]) begin
            seq_armed_r <= 1'b0;
        end else if (seq_armed_r && (hit[2] || hit[0])) begin
            seq_armed_r <= 1'b0;
        end else if (hit[3] || hit[1]) begin
            seq_armed_r <= 1'b1;
        end
    end

    // break requests; after-execution waits for the instruction to retire
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            brk_before_r <= 1'b0;
            brk_after_r <= 1'b0;
            after_pend_r <= 1'b0;
        end else begin
            brk_before_r <= (a_fetch_hit & ~ctrl_r[brk_pkg::BRK_B_AFTER_A]) |
                            (a_hit_raw[3] & ~lbus.fetch) | (a_hit_raw[1] & ~ibus.fetch) |
                            hit[2] | hit[0];
            brk_after_r <= after_pend_r & insn_exec_done;
            if (a_fetch_hit && ctrl_r[brk_pkg::BRK_B_AFTER_A]) begin
                after_pend_r <= 1'b1;
            end else if (insn_exec_done) begin
                after_pend_r <= 1'b0;
            end
        end
    end

    // interrupt: level, high while an unmasked status bit is set
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(stat_r & mask_r);
        end
    end

    // apb answer; unmapped addresses answer with pslverr and zero data
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= brk_pkg::BRK_RDATA_RST;
        end else begin
            pready_r <= apb_req.psel & apb_req.penable & ~pready_r;
            pslverr_r <= apb_req.psel & apb_req.penable & ~pready_r &
                         ~addr_known(apb_req.paddr);
            prdata_r <= brk_pkg::BRK_RDATA_RST;
            if (apb_req.psel && apb_req.penable && !pready_r && !apb_req.pwrite) begin
                unique case (apb_req.paddr)
                    brk_pkg::BRK_OFS_CTRL:
                        prdata_r <= (ctrl_r & ~(32'h0000_000f << brk_pkg::BRK_B_FLAG_LO)) |
                                    ({28'h000_0000, flag_r} << brk_pkg::BRK_B_FLAG_LO);
                    brk_pkg::BRK_OFS_STAT: prdata_r <= {28'h000_0000, stat_r};
                    brk_pkg::BRK_OFS_MASK: prdata_r <= {28'h000_0000, mask_r};
                    brk_pkg::BRK_OFS_ASIDA: prdata_r <= {24'h00_0000, asid_a_r};
                    brk_pkg::BRK_OFS_ASIDB: prdata_r <= {24'h00_0000, asid_b_r};
                    default: prdata_r <= brk_pkg::BRK_RDATA_RST;
                endcase
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign brk_before = brk_before_r;
    assign brk_after = brk_after_r;
    assign pc_trace_en = ctrl_r[brk_pkg::BRK_B_PC_TRACE];
    assign irq = irq_r;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_RSVD_ZERO: assert property (
        pready_r && !pslverr_r && $past(apb_req.paddr) == brk_pkg::BRK_OFS_CTRL
        |-> prdata_r[31:22] == 10'h000 && prdata_r[19:16] == 4'h0)
        else $error("reserved bits of break_control read nonzero");
    AST_ASID_A_CHECK: assert property (
        lbus.valid && lbus.cond_a && !ctrl_r[21] && lbus.asid != asid_a_r
        && !(ctrl_wr && !apb_req.pwdata[15]) && !flag_r[3] |=> !flag_r[3])
        else $error("channel A matched with wrong asid");
    AST_ASID_B_SKIP: assert property (
        ibus.valid && ibus.cond_b && ctrl_r[20] && !ctrl_r[3] |=> flag_r[0])
        else $error("channel B asid mask did not skip compare");
    AST_FLAG_LA: assert property (
        lbus.valid && lbus.cond_a && ctrl_r[21] |=> flag_r[3] && stat_r[3])
        else $error("L bus channel A flag not set");
    AST_FLAG_LB: assert property (
        lbus.valid && lbus.cond_b && ctrl_r[20] && !ctrl_r[3] |=> flag_r[2])
        else $error("L bus channel B flag not set");
    AST_FLAG_IA: assert property (
        ibus.valid && ibus.cond_a && ctrl_r[21] |=> flag_r[1])
        else $error("I bus channel A flag not set");
    AST_FLAG_IB: assert property (
        ibus.valid && ibus.cond_b && ctrl_r[20] && !ctrl_r[3] |=> flag_r[0])
        else $error("I bus channel B flag not set");
    AST_FLAG_STICKY: assert property (
        flag_r[3] && !(ctrl_wr && !apb_req.pwdata[15]) |=> flag_r[3])
        else $error("match flag dropped without a clear");
    AST_TRACE_EN: assert property (
        ctrl_wr |=> pc_trace_en == $past(apb_req.pwdata[11]))
        else $error("trace enable does not follow bit 11");
    // a fetch break that arms while the previous instruction retires starts a fresh wait
    AST_AFTER_EXEC: assert property (
        after_pend_r && insn_exec_done && !(a_fetch_hit && ctrl_r[brk_pkg::BRK_B_AFTER_A])
        |=> brk_after_r ##1 !brk_after_r)
        else $error("after-execution break not raised once");
    AST_SEQ_HOLD: assert property (
        ctrl_r[3] && !seq_armed_r && lbus.cond_b && !lbus.cond_a && !ibus.valid
        && !flag_r[2] && !(ctrl_wr) |=> !flag_r[2])
        else $error("channel B flagged before channel A in sequence");
    AST_SET_WINS: assert property (
        hit[1] && ctrl_wr && !apb_req.pwdata[13] |=> flag_r[1])
        else $error("clear beat a same-cycle match");
    AST_RESET_CLEAN: assert property (
        $past(sys_rst) |-> ctrl_r == brk_pkg::BRK_CTRL_RST && flag_r == brk_pkg::BRK_FLAG_RST
        && !irq_r && !pready_r)
        else $error("state not zero after reset release");
    AST_KEEP_ON_ONE: assert property (
        flag_r[2] && ctrl_wr && apb_req.pwdata[brk_pkg::BRK_B_FLAG_LO + 2] |=> flag_r[2])
        else $error("writing one dropped a match flag");
    AST_CLEAR_ON_ZERO: assert property (
        ctrl_wr && !apb_req.pwdata[brk_pkg::BRK_B_FLAG_LO] && !hit[0] |=> !flag_r[0])
        else $error("writing zero did not clear a match flag");
    AST_FLAG_LA_ASID: assert property (
        lbus.valid && lbus.cond_a && !ctrl_r[brk_pkg::BRK_B_ASID_MASK_A]
        && lbus.asid == asid_a_r |=> flag_r[3])
        else $error("L bus channel A flag not set on asid match");
    AST_FLAG_LB_ASID: assert property (
        lbus.valid && lbus.cond_b && !ctrl_r[brk_pkg::BRK_B_ASID_MASK_B]
        && lbus.asid == asid_b_r && !ctrl_r[brk_pkg::BRK_B_SEQ] |=> flag_r[2])
        else $error("L bus channel B flag not set on asid match");
    AST_FLAG_IA_ASID: assert property (
        ibus.valid && ibus.cond_a && !ctrl_r[brk_pkg::BRK_B_ASID_MASK_A]
        && ibus.asid == asid_a_r |=> flag_r[1])
        else $error("I bus channel A flag not set on asid match");
    AST_FLAG_IB_ASID: assert property (
        ibus.valid && ibus.cond_b && !ctrl_r[brk_pkg::BRK_B_ASID_MASK_B]
        && ibus.asid == asid_b_r && !ctrl_r[brk_pkg::BRK_B_SEQ] |=> flag_r[0])
        else $error("I bus channel B flag not set on asid match");
    AST_ASID_B_CHECK: assert property (
        lbus.valid && lbus.cond_b && !ctrl_r[brk_pkg::BRK_B_ASID_MASK_B]
        && lbus.asid != asid_b_r && !flag_r[2] |=> !flag_r[2])
        else $error("channel B matched with wrong asid");
    AST_TRACE_HOLD: assert property (
        !ctrl_wr |=> $stable(pc_trace_en))
        else $error("trace enable moved without a write");
    AST_BEFORE_FETCH: assert property (
        a_fetch_hit && !ctrl_r[brk_pkg::BRK_B_AFTER_A] |=> brk_before_r)
        else $error("before-execution break not raised");
    AST_AFTER_ARM: assert property (
        a_fetch_hit && ctrl_r[brk_pkg::BRK_B_AFTER_A] |=> after_pend_r)
        else $error("after-execution break not held pending");
    AST_SEQ_ARM: assert property (
        ctrl_r[brk_pkg::BRK_B_SEQ] && (hit[3] || hit[1]) && !seq_armed_r |=> seq_armed_r)
        else $error("channel A match did not arm the sequence");
    AST_SEQ_COUNT: assert property (
        ctrl_r[brk_pkg::BRK_B_SEQ] && seq_armed_r && lbus.valid && lbus.cond_b
        && ctrl_r[brk_pkg::BRK_B_ASID_MASK_B] |=> flag_r[2] && brk_before_r)
        else $error("armed channel B match not counted");
endmodule : brk_ctrl

// ===== brk_bus_mdl.sv
// far-side model: drives the monitored l bus, i bus and execution-done pulse
`timescale 1ns/1ps
module brk_bus_mdl (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // commands from the bench
    input wire logic go,
    input wire logic on_l,
    input wire brk_pkg::brk_bus_t cyc,
    input wire logic exec,
    // monitored buses
    output brk_pkg::brk_bus_t lbus,
    output brk_pkg::brk_bus_t ibus,
    output logic insn_exec_done
);
    // idle fields flip every cycle so the block cannot lean on stale values
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lbus <= '0;
            ibus <= '0;
            insn_exec_done <= 1'b0;
        end else begin
            lbus <= (go && on_l) ? cyc : {1'b0, ~lbus[10:0]};
            ibus <= (go && !on_l) ? cyc : {1'b0, ~ibus[10:0]};
            insn_exec_done <= exec;
        end
    end
endmodule : brk_bus_mdl

// ===== brk_ctrl_tb_top.sv
// self-checking bench for the break control register block
`timescale 1ns/1ps
module brk_ctrl_tb_top;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    brk_pkg::brk_apb_req_t req = '0;
    brk_pkg::brk_bus_t cyc = '0;
    brk_pkg::brk_bus_t lbus;
    brk_pkg::brk_bus_t ibus;
    logic go = 1'b0;
    logic on_l = 1'b0;
    logic exec = 1'b0;
    logic done, brk_before, brk_after, pc_trace_en, irq, pready, pslverr;
    logic [31:0] prdata;
    logic [32:0] exp_q[$];
    logic [7:0] va, vb, want;
    logic [31:0] fl, mb;
    int fail_count = 0;
    int cmp_count = 0;
    int nb = 0;
    int na = 0;
    int n0, m0;

    always #20 mclk = ~mclk;

    brk_ctrl DUT (.mclk(mclk), .sys_rst(sys_rst), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lbus(lbus), .ibus(ibus),
        .insn_exec_done(done), .brk_before(brk_before), .brk_after(brk_after),
        .pc_trace_en(pc_trace_en), .irq(irq));
    brk_bus_mdl MDL (.mclk(mclk), .sys_rst(sys_rst), .go(go), .on_l(on_l), .cyc(cyc),
        .exec(exec), .lbus(lbus), .ibus(ibus), .insn_exec_done(done));

    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int i;
        @(posedge mclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        if (!w) exp_q.push_back(e);
        @(posedge mclk);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            fail_count++;
            report_and_stop();
        end
        req <= '0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {1'b0, d});
    endtask : rd

    // one monitored cycle, then room for the flag and irq to land
    task automatic bus(input logic l, input logic f, input logic [7:0] s, input logic ca,
                       input logic cb);
        @(posedge mclk);
        go <= 1'b1;
        on_l <= l;
        cyc <= '{valid: 1'b1, fetch: f, asid: s, cond_a: ca, cond_b: cb};
        @(posedge mclk);
        go <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : bus

    // read results are paired with the oldest expectation
    always @(posedge mclk) begin
        if (brk_before === 1'b1) nb++;
        if (brk_after === 1'b1) na++;
        if (pready === 1'b1 && req.pwrite === 1'b0) begin
            if (exp_q.size() == 0) chk(33'h1, 33'h0);
            else chk({pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        void'($urandom(68880));
        va = 8'($urandom);
        vb = 8'($urandom);
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(brk_pkg::BRK_OFS_CTRL, 32'h0);
        chk(pc_trace_en, 1'b0);
        wr(brk_pkg::BRK_OFS_CTRL, 32'h0030_ffff);
        rd(brk_pkg::BRK_OFS_CTRL, 32'h0030_0c08);
        chk(pc_trace_en, 1'b1);
        apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
        wr(brk_pkg::BRK_OFS_ASIDA, {24'h0, va});
        wr(brk_pkg::BRK_OFS_ASIDB, {24'h0, vb});
        rd(brk_pkg::BRK_OFS_ASIDA, {24'h0, va});
        for (int k = 3; k >= 0; k--) begin
            fl = 32'h1 << (12 + k);
            mb = k[0] ? 32'h0020_0000 : 32'h0010_0000;
            want = k[0] ? va : vb;
            wr(brk_pkg::BRK_OFS_CTRL, 32'h0);
            bus(k[1], 1'b0, ~want, k[0], !k[0]);
            rd(brk_pkg::BRK_OFS_CTRL, 32'h0);
            bus(k[1], 1'b0, want, k[0], !k[0]);
            rd(brk_pkg::BRK_OFS_CTRL, fl);
            wr(brk_pkg::BRK_OFS_CTRL, fl | mb);
            rd(brk_pkg::BRK_OFS_CTRL, fl | mb);
            wr(brk_pkg::BRK_OFS_CTRL, mb);
            rd(brk_pkg::BRK_OFS_CTRL, mb);
            bus(k[1], 1'b0, ~want, k[0], !k[0]);
            rd(brk_pkg::BRK_OFS_CTRL, fl | mb);
        end
        rd(brk_pkg::BRK_OFS_STAT, 32'h0000_000f);
        chk(irq, 1'b0);
        wr(brk_pkg::BRK_OFS_MASK, 32'h0000_0008);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1);
        wr(brk_pkg::BRK_OFS_STAT, 32'h0000_0007);
        rd(brk_pkg::BRK_OFS_STAT, 32'h0000_0008);
        wr(brk_pkg::BRK_OFS_MASK, 32'h0);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        wr(brk_pkg::BRK_OFS_MASK, 32'h0000_0008);
        wr(brk_pkg::BRK_OFS_STAT, 32'h0000_0008);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        bus(1'b1, 1'b0, va, 1'b1, 1'b0);
        chk(irq, 1'b1);
        // fetch break timing, before then after execution
        wr(brk_pkg::BRK_OFS_CTRL, 32'h0020_0000);
        n0 = nb;
        bus(1'b1, 1'b1, 8'h00, 1'b1, 1'b0);
        chk(nb - n0, 1);
        wr(brk_pkg::BRK_OFS_CTRL, 32'h0020_0400);
        n0 = nb;
        m0 = na;
        bus(1'b1, 1'b1, 8'h00, 1'b1, 1'b0);
        chk(nb - n0, 0);
        exec <= 1'b1;
        @(posedge mclk);
        exec <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(na - m0, 1);
        // sequential mode: a lone channel b hit must not break
        wr(brk_pkg::BRK_OFS_CTRL, 32'h0030_0008);
        n0 = nb;
        bus(1'b1, 1'b0, 8'h00, 1'b0, 1'b1);
        chk(nb - n0, 0);
        bus(1'b1, 1'b0, 8'h00, 1'b1, 1'b0);
        bus(1'b1, 1'b0, 8'h00, 1'b0, 1'b1);
        chk(nb - n0, 2);
        // an I bus channel A match lands on the edge that writes zero to its flag
        fork
            wr(brk_pkg::BRK_OFS_CTRL, 32'h0020_0000);
            begin
                repeat (2) @(posedge mclk);
                go <= 1'b1;
                on_l <= 1'b0;
                cyc <= '{valid: 1'b1, fetch: 1'b0, asid: 8'h00, cond_a: 1'b1, cond_b: 1'b0};
                @(posedge mclk);
                go <= 1'b0;
            end
        join
        rd(brk_pkg::BRK_OFS_CTRL, 32'h0020_2000);
        repeat (5) @(posedge mclk);
        report_and_stop();
    end
endmodule : brk_ctrl_tb_top
